// file: rtl/ppe_pkg.sv
// package for the phy port event and status register block
package ppe_pkg;

	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned REG_W    = 16;
	localparam int unsigned EVENT_W  = 8;

	// register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_SOURCE   = 8'h1d;
	localparam logic [ADDR_W-1:0] IDX_MASK     = 8'h1e;
	localparam logic [ADDR_W-1:0] IDX_SPECIAL  = 8'h1f;
	localparam logic [ADDR_W-1:0] IDX_MODE_CS  = 8'h11;

	// event bit positions, shared by source flags and mask
	localparam int unsigned BIT_PAGE_RX    = 1;
	localparam int unsigned BIT_PAR_FAULT  = 2;
	localparam int unsigned BIT_PARTNER_ACK = 3;
	localparam int unsigned BIT_LINK_DOWN  = 4;
	localparam int unsigned BIT_REM_FAULT  = 5;
	localparam int unsigned BIT_NEG_DONE   = 6;
	localparam int unsigned BIT_ENERGY     = 7;
	localparam logic [EVENT_W-1:0] EVENT_BITS = 8'hfe;

	// special control/status fields
	localparam int unsigned BIT_NEG_COMPLETE = 12;
	localparam int unsigned SPEED_LSB        = 2;
	localparam int unsigned BIT_SPARE_LO     = 0;

	// mode control/status crossover and energy status fields
	localparam int unsigned BIT_XO_SOURCE = 15;
	localparam int unsigned BIT_XO_AUTO   = 14;
	localparam int unsigned BIT_XO_STATE  = 13;
	localparam int unsigned BIT_ENERGY_ST = 1;

	localparam logic [EVENT_W-1:0] MASK_RESET    = 8'h00;
	localparam logic [EVENT_W-1:0] FLAGS_RESET   = 8'h00;
	localparam logic [2:0]         SPEED_RESET   = 3'h0;
	localparam logic [1:0]         SPARE_RESET   = 2'h0;

	localparam logic [2:0] SPEED_10_HD  = 3'h1;
	localparam logic [2:0] SPEED_100_HD = 3'h2;
	localparam logic [2:0] SPEED_10_FD  = 3'h5;
	localparam logic [2:0] SPEED_100_FD = 3'h6;

	// events reported by the phy line logic, one cycle pulses
	typedef struct packed {
		logic energy;
		logic neg_done;
		logic remote_fault;
		logic link_down;
		logic partner_ack;
		logic parallel_fault;
		logic page_rx;
	} ppe_events_t;

	// live phy status
	typedef struct packed {
		logic       energy_detected;
		logic       neg_complete;
		logic [2:0] speed;
	} ppe_status_t;

	// resolved cable crossover drive
	typedef struct packed {
		logic auto_mode;
		logic crossed;
	} ppe_xover_t;

	typedef enum logic [2:0] {
		APB_IDLE   = 3'b001,
		APB_ACCESS = 3'b010,
		APB_DONE   = 3'b100
	} ppe_apb_state_t;

endpackage

// file: rtl/ppe_regs.sv
// phy port event flags, mask, special status and crossover control over apb
// Contract
// R01 - auto bit 0: manual, state picks crossed
// R02 - auto 1, state 0: automatic crossover
// R03 - software never writes auto and state both
// R04 - bits act only when source bit set
// R05 - flags latch on event when enabled
// R06 - reading source returns then clears flags
// R07 - mask read/write, reset 0, 1 enables
// R08 - bit 7 latches on energy detect rise
// R09 - bit 6 latches on negotiation complete
// R10 - bit 5 latches on remote fault
// R11 - bit 4 latches on link down
// R12 - bit 3 latches on partner acknowledge
// R13 - bit 2 latches on parallel detect fault
// R14 - bit 1 latches on page received
// R15 - bit 12 reports negotiation complete
// R16 - bits 4:2 report resolved speed code
// R17 - irq while any enabled flag set
//
// Local design decision: register access over APB.
module ppe_regs #(
	parameter int unsigned PADDR_W = 12
) (
	input  wire logic                ref_clk,
	input  wire logic                srst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [PADDR_W-1:0]  paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	input  wire ppe_pkg::ppe_events_t phy_events,
	input  wire ppe_pkg::ppe_status_t phy_status,
	input  wire logic                strap_manual_crossed,
	input  wire logic                strap_auto_enable,
	output ppe_pkg::ppe_xover_t      xover,
	output logic                     phy_irq
);
	import ppe_pkg::*;

	logic [EVENT_W-1:0] flags;
	logic [EVENT_W-1:0] mask;
	logic [EVENT_W-1:0] raw_events;
	logic [EVENT_W-1:0] hits;
	logic               energy_prev;
	logic               xo_source;
	logic               xo_auto;
	logic               xo_state;
	logic [1:0]         spare_lo;
	logic               setup;
	logic               wr_en;
	logic               rd_source;
	logic [ADDR_W-1:0]  idx;
	logic               mapped;
	logic [REG_W-1:0]   rd_word;
	logic               neg_complete;
	logic [2:0]         speed;
	ppe_apb_state_t     state;

	function automatic logic [REG_W-1:0] mode_word(input logic s,
		input logic a, input logic t, input logic e);
		logic [REG_W-1:0] w;
		w = '0;
		w[BIT_XO_SOURCE] = s;
		w[BIT_XO_AUTO]   = a;
		w[BIT_XO_STATE]  = t;
		w[BIT_ENERGY_ST] = e;
		return w;
	endfunction

	// the word index must fit inside paddr above the byte lanes
	if (PADDR_W < ADDR_W + 2) begin : g_paddr_check
		$error("paddr too narrow for the register index");
	end

	// index of a word address; unaligned bits ignored
	assign idx = paddr[ADDR_W+1:2];
	assign mapped = ((paddr >> (ADDR_W + 2)) == '0) &&
		(idx == IDX_SOURCE || idx == IDX_MASK ||
		 idx == IDX_SPECIAL || idx == IDX_MODE_CS);
	assign setup = psel && !penable && state == APB_IDLE;
	// no wait state: writes and read clears land on the completing edge
	assign wr_en = state == APB_ACCESS && psel && penable && pwrite && mapped;
	assign rd_source = state == APB_ACCESS && psel && penable && !pwrite &&
		idx == IDX_SOURCE && mapped; // R06

	always_comb begin
		raw_events = '0;
		raw_events[BIT_ENERGY]      = phy_status.energy_detected &&
			!energy_prev; // R08
		raw_events[BIT_NEG_DONE]    = phy_events.neg_done; // R09
		raw_events[BIT_REM_FAULT]   = phy_events.remote_fault; // R10
		raw_events[BIT_LINK_DOWN]   = phy_events.link_down; // R11
		raw_events[BIT_PARTNER_ACK] = phy_events.partner_ack; // R12
		raw_events[BIT_PAR_FAULT]   = phy_events.parallel_fault; // R13
		raw_events[BIT_PAGE_RX]     = phy_events.page_rx; // R14
		raw_events = raw_events | ({EVENT_W{phy_events.energy}} &
			(EVENT_W'(1) << BIT_ENERGY));
		hits = raw_events & mask & EVENT_BITS; // R05
	end

	always_comb begin
		rd_word = '0;
		case (idx)
			IDX_SOURCE: rd_word[EVENT_W-1:0] = flags;
			IDX_MASK: rd_word[EVENT_W-1:0] = mask;
			IDX_SPECIAL: begin
				rd_word[BIT_NEG_COMPLETE] = neg_complete; // R15
				rd_word[SPEED_LSB+:3] = speed; // R16
				rd_word[BIT_SPARE_LO+:2] = spare_lo;
			end
			IDX_MODE_CS: rd_word = mode_word(xo_source, xo_auto, xo_state,
				phy_status.energy_detected);
			default: rd_word = '0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			energy_prev <= 1'b0;
		end else begin
			energy_prev <= phy_status.energy_detected;
		end
	end

	// status is held in flops so that the fields read zero out of reset
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			neg_complete <= 1'b0;
			speed        <= SPEED_RESET;
		end else begin
			neg_complete <= phy_status.neg_complete; // R15
			speed        <= phy_status.speed; // R16
		end
	end

	// the read clears only what it returned at its setup edge, so an
	// event in either cycle of the read stays latched for the next one
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flags <= FLAGS_RESET;
		end else if (rd_source) begin
			flags <= (flags & ~prdata[EVENT_W-1:0]) | hits; // R06
		end else begin
			flags <= flags | hits; // R05
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mask <= MASK_RESET;
		end else if (wr_en && idx == IDX_MASK && pstrb[0]) begin
			mask <= pwdata[EVENT_W-1:0] & EVENT_BITS; // R07
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			spare_lo <= SPARE_RESET;
		end else if (wr_en && idx == IDX_SPECIAL && pstrb[0]) begin
			spare_lo <= pwdata[BIT_SPARE_LO+:2];
		end
	end

	// software keeps auto and state from both being one
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			xo_source <= 1'b0;
			xo_auto   <= 1'b0;
			xo_state  <= 1'b0;
		end else if (wr_en && idx == IDX_MODE_CS && pstrb[1]) begin
			xo_source <= pwdata[BIT_XO_SOURCE];
			xo_auto   <= pwdata[BIT_XO_AUTO];
			xo_state  <= pwdata[BIT_XO_STATE]; // R03
		end
	end

	// reserved auto+state pattern falls back to automatic
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			xover <= '0;
		end else if (xo_source) begin // R04
			xover.auto_mode <= xo_auto; // R02
			xover.crossed   <= !xo_auto && xo_state; // R01
		end else begin
			xover.auto_mode <= strap_auto_enable; // R04
			xover.crossed   <= !strap_auto_enable && strap_manual_crossed;
		end
	end

	// irq follows flags a cycle later; flags latch only enabled events and stay set if later masked
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phy_irq <= 1'b0;
		end else begin
			phy_irq <= |(flags & mask); // R17
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= APB_IDLE;
		end else begin
			case (state)
				APB_IDLE: if (setup) begin
					state <= APB_ACCESS;
				end
				APB_ACCESS: state <= APB_DONE;
				APB_DONE: state <= APB_IDLE;
				default: state <= APB_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (state == APB_IDLE && setup) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
			pslverr <= !mapped;
		end else begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end
	end

endmodule

// file: test/ppe_checker.sv
// concurrent checks on the ppe_regs ports
module ppe_checker (
	input wire logic                 ref_clk,
	input wire logic                 srst,
	input wire logic                 psel,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic                 pready,
	input wire logic [31:0]          prdata,
	input wire logic                 pslverr,
	input wire ppe_pkg::ppe_events_t phy_events,
	input wire ppe_pkg::ppe_status_t phy_status,
	input wire logic                 phy_irq
);
	import ppe_pkg::*;
	wire logic [7:0] idx = paddr[9:2];
	wire logic       page0 = paddr[11:10] == 2'b00;
	wire logic       rd_src = pready && !pwrite && page0 &&
		idx == IDX_SOURCE;
	wire logic       rd_spc = pready && !pwrite && page0 &&
		idx == IDX_SPECIAL;
	wire logic       wr_msk = pready && pwrite && page0 &&
		idx == IDX_MASK;
	wire logic       map = page0 && idx inside {IDX_SOURCE, IDX_MASK,
		IDX_SPECIAL, IDX_MODE_CS};
	logic            en_q;
	logic            quiet_q;
	// no event pulse and no rise of the energy level in this cycle
	wire logic       quiet = phy_events == '0 &&
		!(phy_status.energy_detected && !en_q);
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			en_q    <= 1'b0;
			quiet_q <= 1'b1;
		end else begin
			en_q    <= phy_status.energy_detected;
			quiet_q <= quiet;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	rdy_answer_a: assert property ($rose(psel) |=> pready)
		else $error("no answer after setup");
	rdy_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	map_err_a: assert property (pready |-> pslverr == !map)
		else $error("pslverr wrong for address");
	rd_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero when idle");
	upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
		else $error("upper read bits set");
	// events at either edge of the read are kept, so only a quiet read
	irq_fall_a: assert property (
		rd_src && quiet && quiet_q |=> ##1 !phy_irq)
		else $error("irq stayed after clearing read");
	// a mask write that enables a held flag may raise irq as well
	irq_rise_a: assert property ($rose(phy_irq) |->
		$past(phy_events, 2) != '0 ||
		$past(phy_status.energy_detected, 2) || $past(wr_msk, 2))
		else $error("irq rose without event");
	stat_read_a: assert property (rd_spc |-> prdata[12:2] ==
		{$past(phy_status.neg_complete, 2), 7'h0,
		$past(phy_status.speed, 2)})
		else $error("special status read wrong");
endmodule
bind ppe_regs ppe_checker chk (.ref_clk, .srst, .psel, .pwrite, .paddr,
	.pready, .prdata, .pslverr, .phy_events, .phy_status, .phy_irq);

// file: test/testbench.sv
// self-checking bench for ppe_regs
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import ppe_pkg::*;
	logic        ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic        pready, pslverr, phy_irq, er, a, x, src;
	logic        strap_manual_crossed = 0, strap_auto_enable = 0;
	logic [11:0] paddr = '0;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [2:0]  cd [4] = '{SPEED_10_HD, SPEED_100_HD, SPEED_10_FD,
		SPEED_100_FD};
	ppe_events_t phy_events = '0;
	ppe_status_t phy_status = '0;
	ppe_xover_t  xover;
	int          err_count = 0, check_count = 0, cyc = 0, mm, b, k;
	int          mdl_mask = 0, mdl_flags = 0;
	int          exp_q [$];
	ppe_regs DUT (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .pready, .prdata, .pslverr, .phy_events,
		.phy_status, .strap_manual_crossed, .strap_auto_enable, .xover,
		.phy_irq);
	initial forever #20 ref_clk = ~ref_clk;
	task final_report;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			final_report;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %0t got %h want %h", $time, s, e);
		end
	endtask
	// the leading edge keeps psel low one cycle between transfers
	task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= {2'b0, i, 2'b0};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	initial begin
		void'($urandom(32'h9a35));
		repeat (5) @(posedge ref_clk);
		srst <= 0;
		apb(0, IDX_MASK, 0);
		chk(rd, 0);
		apb(0, IDX_SOURCE, 0);
		chk(rd, 0);
		apb(1, 8'h40, 32'hff);
		chk(er, 1);
		$display("test 1 done");
		// each event once enabled, once masked
		for (b = 0; b < 14; b++) begin
			k = b % 7 + 1;
			mm = $urandom & 32'hfe;
			mm = (b < 7) ? mm | (1 << k) : mm & ~(1 << k);
			apb(1, IDX_MASK, mm);
			mdl_mask = mm;
			apb(0, IDX_MASK, 0);
			chk(rd, mdl_mask);
			@(posedge ref_clk) phy_events <= 7'(1 << (k - 1));
			@(posedge ref_clk) phy_events <= '0;
			mdl_flags |= mdl_mask & (1 << k);
			exp_q.push_back(mdl_flags);
			repeat (3) @(posedge ref_clk);
			chk(phy_irq, (mdl_flags & mdl_mask) != 0);
			apb(0, IDX_SOURCE, 0);
			chk(rd, exp_q.pop_front());
			mdl_flags = 0;
			apb(0, IDX_SOURCE, 0);
			chk(rd, mdl_flags);
			chk(phy_irq, 0);
		end
		$display("test 2 done");
		apb(1, IDX_SPECIAL, 32'hffff);
		for (b = 0; b < 4; b++) begin
			@(posedge ref_clk) phy_status <= {1'b0, b[0], cd[b]};
			apb(0, IDX_SPECIAL, 0);
			chk(rd, (b[0] << 12) | (cd[b] << 2) | 3);
		end
		$display("test 3 done");
		// inverted straps while register control is on prove the override
		for (b = 0; b < 6; b++) begin
			a = b % 3 == 2;
			x = b % 3 == 1;
			src = b >= 3;
			strap_auto_enable <= a ^ src;
			strap_manual_crossed <= x ^ src;
			apb(1, IDX_MODE_CS, {src, a, x} << 13);
			repeat (2) @(posedge ref_clk);
			chk(xover.auto_mode, a);
			if (!a) chk(xover.crossed, x);
		end
		// the energy level rising, not only its pulse, sets bit 7
		apb(1, IDX_MASK, 32'h80);
		@(posedge ref_clk) phy_status.energy_detected <= 1'b1;
		repeat (2) @(posedge ref_clk);
		apb(0, IDX_SOURCE, 0);
		chk(rd, 1 << BIT_ENERGY);
		apb(0, IDX_MODE_CS, 0);
		chk(rd, (1 << BIT_XO_SOURCE) | (1 << BIT_XO_AUTO) |
			(1 << BIT_ENERGY_ST));
		$display("test 4 done");
		apb(1, IDX_MASK, 32'hfe);
		// a write with lane 0 off must leave the mask alone
		pstrb <= 4'he;
		apb(1, IDX_MASK, 32'h0);
		pstrb <= 4'hf;
		apb(0, IDX_MASK, 0);
		chk(rd, 32'hfe);
		@(posedge ref_clk) phy_events <= 7'h7f;
		@(posedge ref_clk) phy_events <= '0;
		srst <= 1;
		repeat (2) @(posedge ref_clk);
		srst <= 0;
		apb(0, IDX_MASK, 0);
		chk(rd, 0);
		chk(phy_irq, 0);
		apb(0, IDX_SOURCE, 0);
		chk(rd, 0);
		$display("test 5 done");
		final_report;
	end
endmodule
